// ---- dtc_pin_model.sv ----
module dtc_pin_model (
    // clock
    input  wire logic       mclk_i,
    // commands from the bench
    input  wire logic       start_i,
    input  wire logic [7:0] hold_i,
    input  wire logic [7:0] falls_i,
    input  wire logic       gate_i,
    // pins towards the block, busy flag back to the bench
    output logic            count_pin_o,
    output logic            gate_pin_o,
    output logic            busy_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [7:0] left_reg = 8'h00;
    logic [7:0] cnt_reg  = 8'h00;
    logic       pin_reg  = 1'b1;

    assign count_pin_o = pin_reg;

    // each level is held for hold_i clocks, one falling edge per low phase
    always_ff @(posedge mclk_i) begin
        if (start_i) begin
            left_reg <= falls_i;
            cnt_reg  <= hold_i;
        end else if (left_reg != 8'h00) begin
            if (cnt_reg == 8'h01) begin
                cnt_reg     <= hold_i;
                pin_reg <= ~pin_reg;
                if (pin_reg == 1'b0) begin
                    left_reg <= left_reg - 8'h01;
                end
            end else begin
                cnt_reg <= cnt_reg - 8'h01;
            end
        end
    end

    assign busy_o     = (left_reg != 8'h00);
    assign gate_pin_o = gate_i;
endmodule : dtc_pin_model

// ---- dtc_pkg.sv ----
package dtc_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_MODE  = 8'h00;
    localparam logic [7:0] ADDR_CTRL  = 8'h04;
    localparam logic [7:0] ADDR_T0_LO = 8'h08;
    localparam logic [7:0] ADDR_T0_HI = 8'h0c;
    localparam logic [7:0] ADDR_T1_LO = 8'h10;
    localparam logic [7:0] ADDR_T1_HI = 8'h14;
    localparam logic [7:0] ADDR_CLK   = 8'h18;
    // mode register: timer 0 in bits 3:0, timer 1 in bits 7:4
    localparam int MODE_T1_SHIFT = 4;
    localparam int MODE_LO_POS   = 0;
    localparam int MODE_HI_POS   = 1;
    localparam int SRC_POS       = 2;
    localparam int GATE_POS      = 3;
    // control register
    localparam int T0_RUN_POS    = 4;
    localparam int T0_OVF_POS    = 5;
    localparam int T1_RUN_POS    = 6;
    localparam int T1_OVF_POS    = 7;
    localparam logic [7:0] CTRL_USED_MASK = 8'hf0;
    // clock configuration register
    localparam int T0_CLKSEL_POS = 0;
    localparam int T1_CLKSEL_POS = 1;
    localparam int X2_POS        = 2;
    // reset values
    localparam logic [7:0] MODE_RST  = 8'h00;
    localparam logic [7:0] CTRL_RST  = 8'h00;
    localparam logic [7:0] CLK_RST   = 8'h00;
    localparam logic [7:0] COUNT_RST = 8'h00;
    // timing: timer clocks per peripheral cycle
    localparam int PER_TICKS = 6;

    typedef enum logic [1:0] {
        MODE_13BIT  = 2'b00,
        MODE_16BIT  = 2'b01,
        MODE_RELOAD = 2'b10,
        MODE_SPLIT  = 2'b11
    } dtc_mode_t;
endpackage : dtc_pkg

// ---- dtc_tick.sv ----
module dtc_tick #(
    parameter int PER_TICKS = dtc_pkg::PER_TICKS
) (
    // clock and reset
    input  wire logic mclk_i,
    input  wire logic sys_rst_i,
    // configuration
    input  wire logic clk_sel_i,
    input  wire logic x2_i,
    // external count pin
    input  wire logic pin_i,
    // events
    output logic      pcycle_o,
    output logic      fall_o
);
    logic [2:0] cnt_reg;
    logic       div_reg;
    logic       smp_reg;
    logic       fall_reg;
    wire        tclk_en;
    wire        last;

    // timer clock is osc/2 unless x2 runs the peripheral clock at osc and clock select picks the peripheral clock
    assign tclk_en  = (clk_sel_i | ~x2_i) ? div_reg : 1'b1;
    assign last     = (cnt_reg == 3'(PER_TICKS - 1));
    assign pcycle_o = tclk_en & last;
    assign fall_o   = fall_reg;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            div_reg  <= 1'b0;
            cnt_reg  <= 3'h0;
            smp_reg  <= 1'b0;
            fall_reg <= 1'b0;
        end else begin
            div_reg  <= ~div_reg;
            if (tclk_en)
                cnt_reg <= last ? 3'h0 : cnt_reg + 3'h1;
            // one sample per peripheral cycle, high then low counts
            fall_reg <= pcycle_o & smp_reg & ~pin_i;
            if (pcycle_o)
                smp_reg <= pin_i;
        end
    end

    AST_FALL_SAMPLE: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        fall_o |-> $past(pcycle_o) && !$past(pin_i))
        else $error("falling edge reported without a low sample");
endmodule : dtc_tick

// ---- dtc_unit.sv ----
// Functional notes
// - two independent 16-bit timer/counters
// - low byte carries into high, high sets flag
// - run bit starts without clearing counts
// - source select picks peripheral clock or pin
// - timer advances once per six timer clocks
// - pin sampled each cycle, high-low counts
// - edge needs two cycles, max rate twelfth
// - clock select picks osc/2 or peripheral clock
// - timer 0 uses mode low nibble, control bits
// - gate bit lets gate pin enable counting
// - rollover to zero sets overflow flag
// - mode 0 five-bit prescaler feeds high byte
// - mode 0 low byte upper bits ignored
// - mode 1 cascades bytes into sixteen bits
// - mode 2 reloads low byte from high
// - mode 3 high byte uses timer 1 bits
// - timer 1 mode 3 halts and holds
module dtc_unit #(
    parameter int PER_TICKS = dtc_pkg::PER_TICKS
) (
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        sys_rst_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // external pins
    input  wire logic        timer0_count_pin_i,
    input  wire logic        timer1_count_pin_i,
    input  wire logic        timer0_gate_pin_i,
    input  wire logic        timer1_gate_pin_i,
    // interrupt acknowledge and requests
    input  wire logic [1:0]  irq_ack_i,
    output logic             timer0_overflow_flag_o,
    output logic             timer1_overflow_flag_o
);
    ////////////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0]  mode_reg;
    logic [7:0]  ctrl_reg;
    logic [7:0]  clk_reg;
    logic [7:0]  t0_lo_reg;
    logic [7:0]  t0_hi_reg;
    logic [7:0]  t1_lo_reg;
    logic [7:0]  t1_hi_reg;
    logic [31:0] prdata_reg;
    logic [7:0]  ctrl_next;
    logic [7:0]  t0_hi_next;

    // one counting step: returns {overflow, high, low}
    function automatic logic [16:0] step(input dtc_pkg::dtc_mode_t m,
                                         input logic [7:0] hi, input logic [7:0] lo);
        logic [16:0] r;
        logic [5:0]  p;
        r = {1'b0, hi, lo};
        p = {1'b0, lo[4:0]} + 6'h01;
        unique case (m)
            dtc_pkg::MODE_13BIT: begin
                // upper three low bits are left alone and never counted
                r[4:0] = p[4:0];
                if (p[5])
                    r[16:8] = {1'b0, hi} + 9'h001;
            end
            dtc_pkg::MODE_16BIT: r = {1'b0, hi, lo} + 17'h00001;
            dtc_pkg::MODE_RELOAD: begin
                r[7:0] = lo + 8'h01;
                if (lo == 8'hff) begin
                    r[7:0] = hi;
                    r[16]  = 1'b1;
                end
            end
            dtc_pkg::MODE_SPLIT: begin
                r[7:0] = lo + 8'h01;
                r[16]  = (lo == 8'hff);
            end
        endcase
        return r;
    endfunction : step

    ////////////////////////////////////////////////////////////////////////////////
    // apb decode
    wire setup   = psel_i & ~penable_i;
    wire access  = psel_i & penable_i;
    wire wr_en   = access & pwrite_i;
    wire hit_mode = (paddr_i == dtc_pkg::ADDR_MODE);
    wire hit_ctrl = (paddr_i == dtc_pkg::ADDR_CTRL);
    wire hit_t0l  = (paddr_i == dtc_pkg::ADDR_T0_LO);
    wire hit_t0h  = (paddr_i == dtc_pkg::ADDR_T0_HI);
    wire hit_t1l  = (paddr_i == dtc_pkg::ADDR_T1_LO);
    wire hit_t1h  = (paddr_i == dtc_pkg::ADDR_T1_HI);
    wire hit_clk  = (paddr_i == dtc_pkg::ADDR_CLK);
    wire hit_any  = hit_mode | hit_ctrl | hit_t0l | hit_t0h | hit_t1l | hit_t1h | hit_clk;
    wire wr_ctrl  = wr_en & hit_ctrl;
    wire wr_t0l   = wr_en & hit_t0l;
    wire wr_t0h   = wr_en & hit_t0h;
    wire wr_t1l   = wr_en & hit_t1l;
    wire wr_t1h   = wr_en & hit_t1h;
    wire [7:0] wbyte = pwdata_i[7:0];

    wire [7:0] rd_byte = hit_mode ? mode_reg
                       : hit_ctrl ? (ctrl_reg & dtc_pkg::CTRL_USED_MASK)
                       : hit_t0l  ? t0_lo_reg
                       : hit_t0h  ? t0_hi_reg
                       : hit_t1l  ? t1_lo_reg
                       : hit_t1h  ? t1_hi_reg
                       : hit_clk  ? clk_reg
                       : 8'h00;

    assign pready_o  = 1'b1;
    assign pslverr_o = access & ~hit_any;
    assign prdata_o  = prdata_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // control fields
    wire [3:0] t0_cfg = mode_reg[3:0];
    wire [3:0] t1_cfg = mode_reg[dtc_pkg::MODE_T1_SHIFT +: 4];
    wire dtc_pkg::dtc_mode_t t0_mode = dtc_pkg::dtc_mode_t'(t0_cfg[1:0]);
    wire dtc_pkg::dtc_mode_t t1_mode = dtc_pkg::dtc_mode_t'(t1_cfg[1:0]);
    wire t0_run   = ctrl_reg[dtc_pkg::T0_RUN_POS];
    wire t1_run   = ctrl_reg[dtc_pkg::T1_RUN_POS];
    wire t0_split = (t0_mode == dtc_pkg::MODE_SPLIT);
    wire x2       = clk_reg[dtc_pkg::X2_POS];

    // gate bit clear: run bit alone; set: gate pin too
    wire t0_enable = t0_run & (~t0_cfg[dtc_pkg::GATE_POS] | timer0_gate_pin_i);
    wire t1_enable = t1_run & (~t1_cfg[dtc_pkg::GATE_POS] | timer1_gate_pin_i);

    ////////////////////////////////////////////////////////////////////////////////
    // peripheral cycle and pin sampling per timer
    logic pcyc0;
    logic pcyc1;
    logic fall0;
    logic fall1;

    dtc_tick #(.PER_TICKS(PER_TICKS)) u_tick0 (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .clk_sel_i (clk_reg[dtc_pkg::T0_CLKSEL_POS]),
        .x2_i      (x2),
        .pin_i     (timer0_count_pin_i),
        .pcycle_o  (pcyc0),
        .fall_o    (fall0)
    );

    dtc_tick #(.PER_TICKS(PER_TICKS)) u_tick1 (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .clk_sel_i (clk_reg[dtc_pkg::T1_CLKSEL_POS]),
        .x2_i      (x2),
        .pin_i     (timer1_count_pin_i),
        .pcycle_o  (pcyc1),
        .fall_o    (fall1)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // counting
    wire t0_evt = t0_cfg[dtc_pkg::SRC_POS] ? fall0 : pcyc0;
    wire t1_evt = t1_cfg[dtc_pkg::SRC_POS] ? fall1 : pcyc1;
    wire t0_inc = t0_enable & t0_evt;
    // timer 1 in its own mode 3 is frozen whatever its run bit says
    wire t1_inc = t1_enable & t1_evt & (t1_mode != dtc_pkg::MODE_SPLIT);
    // split high byte: always timer clock, borrows timer 1 run bit
    wire t0h_inc = t0_split & t1_run & pcyc0;

    wire [16:0] t0_res = step(t0_mode, t0_hi_reg, t0_lo_reg);
    wire [16:0] t1_res = step(t1_mode, t1_hi_reg, t1_lo_reg);
    wire        t0_ovf  = t0_inc & t0_res[16];
    wire        t0h_ovf = t0h_inc & (t0_hi_reg == 8'hff);
    // timer 1 loses its flag to the split high byte
    wire        t1_ovf  = t1_inc & t1_res[16] & ~t0_split;

    // hardware set wins over acknowledge and software write
    always_comb begin
        ctrl_next = wr_ctrl ? (wbyte & dtc_pkg::CTRL_USED_MASK) : ctrl_reg;
        if (!wr_ctrl && irq_ack_i[0])
            ctrl_next[dtc_pkg::T0_OVF_POS] = 1'b0;
        if (!wr_ctrl && irq_ack_i[1])
            ctrl_next[dtc_pkg::T1_OVF_POS] = 1'b0;
        if (t0_ovf)
            ctrl_next[dtc_pkg::T0_OVF_POS] = 1'b1;
        if (t0h_ovf | t1_ovf)
            ctrl_next[dtc_pkg::T1_OVF_POS] = 1'b1;
    end

    always_comb begin
        t0_hi_next = t0_hi_reg;
        if (wr_t0h)
            t0_hi_next = wbyte;
        else if (t0h_inc)
            t0_hi_next = t0_hi_reg + 8'h01;
        else if (t0_inc && !t0_split)
            t0_hi_next = t0_res[15:8];
    end

    assign timer0_overflow_flag_o = ctrl_reg[dtc_pkg::T0_OVF_POS];
    assign timer1_overflow_flag_o = ctrl_reg[dtc_pkg::T1_OVF_POS];

    ////////////////////////////////////////////////////////////////////////////////
    // state
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            mode_reg   <= dtc_pkg::MODE_RST;
            ctrl_reg   <= dtc_pkg::CTRL_RST;
            clk_reg    <= dtc_pkg::CLK_RST;
            t0_lo_reg  <= dtc_pkg::COUNT_RST;
            t0_hi_reg  <= dtc_pkg::COUNT_RST;
            t1_lo_reg  <= dtc_pkg::COUNT_RST;
            t1_hi_reg  <= dtc_pkg::COUNT_RST;
            prdata_reg <= 32'h0000_0000;
        end else begin
            if (setup)
                prdata_reg <= {24'h00_0000, rd_byte};
            if (wr_en && hit_mode)
                mode_reg <= wbyte;
            if (wr_en && hit_clk)
                clk_reg <= wbyte & 8'h07;
            ctrl_reg  <= ctrl_next;
            t0_hi_reg <= t0_hi_next;
            // a software preset wins over a count in the same cycle
            if (wr_t0l)
                t0_lo_reg <= wbyte;
            else if (t0_inc)
                t0_lo_reg <= t0_res[7:0];
            if (wr_t1l)
                t1_lo_reg <= wbyte;
            else if (t1_inc)
                t1_lo_reg <= t1_res[7:0];
            if (wr_t1h)
                t1_hi_reg <= wbyte;
            else if (t1_inc)
                t1_hi_reg <= t1_res[15:8];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    wire t0_nowr = !wr_t0l && !wr_t0h;

    AST_STOPPED_HOLDS: assert property (
        !t0_run && !t0h_inc && t0_nowr |=> $stable(t0_lo_reg) && $stable(t0_hi_reg))
        else $error("timer 0 count moved while stopped");
    AST_GATE_BLOCKS: assert property (
        t0_cfg[dtc_pkg::GATE_POS] && !timer0_gate_pin_i && !t0_split && t0_nowr
        |=> $stable(t0_lo_reg))
        else $error("timer 0 counted with gate pin low");
    AST_M1_CARRY: assert property (
        t0_inc && t0_mode == dtc_pkg::MODE_16BIT && t0_lo_reg == 8'hff && t0_nowr
        |=> t0_lo_reg == 8'h00 && t0_hi_reg == $past(t0_hi_reg) + 8'h01)
        else $error("mode 1 carry into high byte wrong");
    AST_ROLLOVER_FLAG: assert property (
        t0_inc && t0_mode == dtc_pkg::MODE_16BIT && {t0_hi_reg, t0_lo_reg} == 16'hffff
        && t0_nowr |=> timer0_overflow_flag_o && t0_lo_reg == 8'h00)
        else $error("rollover did not set timer 0 flag");
    AST_M0_PRESCALE: assert property (
        t0_inc && t0_mode == dtc_pkg::MODE_13BIT && t0_lo_reg[4:0] == 5'h1f && t0_nowr
        |=> t0_lo_reg[4:0] == 5'h00 && t0_hi_reg == $past(t0_hi_reg) + 8'h01)
        else $error("mode 0 prescaler did not feed high byte");
    AST_RELOAD: assert property (
        t0_inc && t0_mode == dtc_pkg::MODE_RELOAD && t0_lo_reg == 8'hff && t0_nowr
        |=> t0_lo_reg == $past(t0_hi_reg) && $stable(t0_hi_reg) && timer0_overflow_flag_o)
        else $error("mode 2 reload wrong");
    AST_T1_HALT: assert property (
        t1_mode == dtc_pkg::MODE_SPLIT && !wr_t1l && !wr_t1h
        |=> $stable(t1_lo_reg) && $stable(t1_hi_reg))
        else $error("timer 1 moved in mode 3");
    AST_SPLIT_HIGH: assert property (
        t0_split && t1_run && pcyc0 && t0_hi_reg == 8'hff && !wr_t0h
        |=> t0_hi_reg == 8'h00 && timer1_overflow_flag_o)
        else $error("split high byte overflow lost");
    AST_PCYCLE_SPACING: assert property (
        pcyc0 |=> !pcyc0 [*5])
        else $error("peripheral cycle shorter than six timer clocks");
    AST_ACK_CLEARS: assert property (
        irq_ack_i[0] && !t0_ovf && !wr_ctrl |=> !timer0_overflow_flag_o)
        else $error("acknowledge did not clear timer 0 flag");
    AST_SET_WINS: assert property (
        t0_ovf && irq_ack_i[0] |=> timer0_overflow_flag_o)
        else $error("overflow lost against acknowledge");
    // source select and software flag access
    AST_SRC_PIN: assert property (
        t0_cfg[dtc_pkg::SRC_POS] && !fall0 && !wr_t0l |=> $stable(t0_lo_reg))
        else $error("timer 0 counted without a pin edge in counter mode");
    AST_SW_FLAG: assert property (
        wr_ctrl && !t0_ovf |=> timer0_overflow_flag_o == $past(wbyte[dtc_pkg::T0_OVF_POS]))
        else $error("software write did not reach timer 0 flag");
endmodule : dtc_unit

// ---- tb_top.sv ----
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic        mclk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic [1:0]  irq_ack = 2'b00;
    logic        flag0;
    logic        flag1;
    logic        start = 1'b0;
    logic [7:0]  hold = 8'h0c;
    logic [7:0]  falls = 8'h00;
    logic        gate = 1'b0;
    logic        cpin;
    logic        gpin;
    logic        busy;
    int          error_cnt = 0;
    int          check_count = 0;

    dtc_unit dtc_unit_i (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .timer0_count_pin_i(cpin),
        .timer1_count_pin_i(cpin), .timer0_gate_pin_i(gpin), .timer1_gate_pin_i(gpin),
        .irq_ack_i(irq_ack), .timer0_overflow_flag_o(flag0), .timer1_overflow_flag_o(flag1)
    );

    dtc_pin_model dtc_pin_model_i (
        .mclk_i(mclk_i), .start_i(start), .hold_i(hold), .falls_i(falls), .gate_i(gate),
        .count_pin_o(cpin), .gate_pin_o(gpin), .busy_o(busy)
    );

    initial begin
        forever #50 mclk_i = ~mclk_i;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        if (error_cnt == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge mclk_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge mclk_i);
        penable <= 1'b1;
        do begin
            @(posedge mclk_i);
        end while (pready_o !== 1'b1);
        r = prdata_o;
        e = pslverr_o;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 8'h00, r, e);
    endtask : rd

    task automatic wait_flag(input int t, output int n);
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while ((t == 0 ? flag0 : flag1) !== 1'b1 && n < 300);
    endtask : wait_flag

    ////////////////////////////////////////////////////////////////////////////////
    task automatic s_reset;
        logic [31:0] r;
        logic        e;
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, 8'(i * 4), 8'h00, r, e);
            chk(r, 32'h0);
            chk({31'h0, e}, {31'h0, i == 7});
        end
        chk({31'h0, pready_o}, 32'h1);
        wr(dtc_pkg::ADDR_CTRL, 8'hff);
        rd(dtc_pkg::ADDR_CTRL, r);
        chk(r, 32'hf0);
        chk({30'h0, flag1, flag0}, 32'h3);
        wr(dtc_pkg::ADDR_CTRL, 8'h00);
        @(negedge mclk_i);
        chk({30'h0, flag1, flag0}, 32'h0);
    endtask : s_reset

    task automatic period(input int t, input logic [7:0] md, input logic [7:0] ck,
                          input logic [7:0] hi, input int exp);
        logic [31:0] r;
        int          n;
        logic [7:0]  lo_a;
        lo_a = (t == 0) ? dtc_pkg::ADDR_T0_LO : dtc_pkg::ADDR_T1_LO;
        wr(dtc_pkg::ADDR_CTRL, 8'h00);
        wr(dtc_pkg::ADDR_MODE, md);
        wr(dtc_pkg::ADDR_CLK, ck);
        wr(lo_a + 8'h04, hi);
        wr(lo_a, hi);
        wr(dtc_pkg::ADDR_CTRL, (t == 0) ? 8'h10 : 8'h40);
        wait_flag(t, n);
        @(posedge mclk_i);
        irq_ack <= (t == 0) ? 2'b01 : 2'b10;
        @(posedge mclk_i);
        irq_ack <= 2'b00;
        wait_flag(t, n);
        chk(n + 2, exp);
        wr(dtc_pkg::ADDR_CTRL, 8'h00);
        rd(lo_a + 8'h04, r);
        chk(r, {24'h0, hi});
    endtask : period

    task automatic s_roll(input logic [7:0] md, input logic [7:0] lo, input logic [31:0] mask);
        logic [31:0] r;
        int          n;
        wr(dtc_pkg::ADDR_CTRL, 8'h00);
        wr(dtc_pkg::ADDR_MODE, md);
        wr(dtc_pkg::ADDR_CLK, 8'h04);
        wr(dtc_pkg::ADDR_T0_LO, lo);
        wr(dtc_pkg::ADDR_T0_HI, 8'hff);
        irq_ack <= 2'b01;
        wr(dtc_pkg::ADDR_CTRL, 8'h10);
        wait_flag(0, n);
        irq_ack <= 2'b00;
        chk({31'h0, n <= 14}, 32'h1);
        wr(dtc_pkg::ADDR_CTRL, 8'h00);
        rd(dtc_pkg::ADDR_T0_HI, r);
        chk(r, 32'h0);
        rd(dtc_pkg::ADDR_T0_LO, r);
        chk(r & mask, 32'h0);
    endtask : s_roll

    task automatic s_gate;
        logic [31:0] r;
        wr(dtc_pkg::ADDR_MODE, 8'h09);
        wr(dtc_pkg::ADDR_T0_LO, 8'h00);
        gate <= 1'b0;
        wr(dtc_pkg::ADDR_CTRL, 8'h10);
        repeat (40) @(posedge mclk_i);
        rd(dtc_pkg::ADDR_T0_LO, r);
        chk(r, 32'h0);
        gate <= 1'b1;
        repeat (40) @(posedge mclk_i);
        wr(dtc_pkg::ADDR_CTRL, 8'h00);
        rd(dtc_pkg::ADDR_T0_LO, r);
        chk({31'h0, r[7:0] > 8'h00}, 32'h1);
        gate <= 1'b0;
    endtask : s_gate

    task automatic s_count(input logic [7:0] h, input logic [7:0] f, input logic [7:0] exp);
        logic [31:0] r;
        int          n;
        wr(dtc_pkg::ADDR_MODE, 8'h05);
        wr(dtc_pkg::ADDR_CLK, 8'h00);
        wr(dtc_pkg::ADDR_CTRL, 8'h10);
        @(posedge mclk_i);
        hold  <= h;
        falls <= f;
        start <= 1'b1;
        @(posedge mclk_i);
        start <= 1'b0;
        @(posedge mclk_i);
        for (n = 0; n < 3000 && busy !== 1'b0; n++) begin
            @(posedge mclk_i);
        end
        chk({31'h0, busy}, 32'h0);
        repeat (36) @(posedge mclk_i);
        wr(dtc_pkg::ADDR_CTRL, 8'h00);
        rd(dtc_pkg::ADDR_T0_LO, r);
        chk(r, {24'h0, exp});
    endtask : s_count

    task automatic s_halt;
        logic [31:0] r;
        wr(dtc_pkg::ADDR_MODE, 8'h33);
        wr(dtc_pkg::ADDR_T1_LO, 8'h55);
        wr(dtc_pkg::ADDR_T0_HI, 8'hff);
        wr(dtc_pkg::ADDR_CTRL, 8'h40);
        repeat (60) @(posedge mclk_i);
        rd(dtc_pkg::ADDR_T1_LO, r);
        chk(r, 32'h55);
        chk({31'h0, flag1}, 32'h1);
        wr(dtc_pkg::ADDR_CTRL, 8'h00);
    endtask : s_halt

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #1_000_000;
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        repeat (20) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        s_reset();
        period(0, 8'h02, 8'h00, 8'hff, 12);
        period(0, 8'h02, 8'h04, 8'hff, 6);
        period(0, 8'h02, 8'h05, 8'hff, 12);
        period(0, 8'h02, 8'h00, 8'hfe, 24);
        period(1, 8'h20, 8'h00, 8'hff, 12);
        s_roll(8'h01, 8'hfe, 32'hff);
        s_roll(8'h00, 8'hdf, 32'h1f);
        s_gate();
        wr(dtc_pkg::ADDR_T0_LO, 8'h00);
        s_count(8'h0c, 8'h05, 8'h05);
        s_count(8'h1e, 8'h03, 8'h08);
        s_halt();
        tally_and_finish();
    end
endmodule : tb_top
